// ---- crp_data_path.sv ----
// card reader/punch adapter data path: serial register, column buffer,
// code checking, sense flags and column counter.
// assumes channel sequencing and command decode sit outside and drive the
// op_ and cond inputs from core_clk logic.
//
// Contract
// - columns move bit-serially on one shared line while strobe is high.
// - during strobe issue exactly twelve clock pulses, shifting the register.
// - serial register is three 4-bit right-shift stages, shifting on falls.
// - reading, strobe drop makes a buffer shift loading the serial word.
// - punching, strobe rise loads one buffer column into the register.
// - buffer is a static store, 12 bits wide and 100 ranks deep.
// - buffer input is serial register in reads, code selector in punch.
// - each shift loads rank one and advances others; last rank visible.
// - flag bad code when two or more of buffer bits 1..7 are set.
// - bad code sets data check only in translated reads.
// - converter turns buffer output into a byte on mux input 0.
// - card-image read sends each column as two bytes on inputs 1, 2.
// - sense flags come from decode, tag, bad code and error line.
// - any sense flag setting sets unit check unless sense is running.
// - feed request starts a feed; offset with it diverts the card.
// - clock sent to the reader has a one microsecond period.
// - with card_at_read_station float the driver; otherwise drive punch data.
// - counter presets to 78 or 99 for 5 us, underflows after zero.
// - each underflow toggles the load-complete flag.
// - preset is 99 with card_at_read_station, else 78.
// - timing chain alternates 500 ns shift with 1 us count phase.
// - master clear resets control flags while asserted.
`timescale 1ns/1ps
module crp_data_path
  import crp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic rp_strobe,
  input wire logic rp_card_at_read_station,
  input wire logic rp_ready,
  input wire logic rp_error,
  input wire logic rp_feed_fault,
  input wire logic rp_data_i,
  output logic rp_data_o,
  output logic rp_data_oe,
  output logic rp_sclk,
  output logic rp_feed,
  output logic rp_offset,
  input wire logic op_read,
  input wire logic op_punch,
  input wire logic op_translate,
  input wire logic op_sense,
  input wire logic feed_req,
  input wire logic offset_req,
  input wire logic chan_shift,
  input wire logic [1:0] chan_sel,
  input wire logic [11:0] punch_col,
  input wire logic cond_cmd_reject,
  input wire logic cond_data_check,
  input wire logic cond_intervention,
  input wire logic sense_clear,
  input wire logic status_clear,
  output logic [7:0] chan_byte,
  output logic [11:0] buf_out,
  output logic bad_punch_combo,
  output logic sense_cmd_reject,
  output logic sense_data_check,
  output logic sense_equip_check,
  output logic sense_interv_req,
  output logic unit_check,
  output logic load_complete,
  output logic counter_underflow,
  output logic rdr_ready,
  output logic rdr_feed_fault
);
  localparam int HALF_A = SCLK_HALF_CYC;
  // link side: three-stage filter per pin, change taken when 2nd and 3rd agree
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] filt;
  } crp_link_s;
  typedef struct packed {
    logic [5:0] x1;
    logic [5:0] x2;
    logic [5:0] lvl_d;
    logic [11:0] serial_shift_reg;
    logic [BUF_RANKS-1:0][11:0] bufr;
    logic [3:0] bit_cnt;
    logic sclk;
    logic [9:0] sclk_tmr;
    crp_chain_e chain;
    logic chain_en;
    logic [9:0] chain_tmr;
    logic [9:0] preset_tmr;
    logic [6:0] cnt;
    logic underflow;
    logic load_complete;
    logic cmd_rej;
    logic dchk;
    logic echk;
    logic ireq;
    logic unit_check;
    logic data_o;
    logic data_oe;
    logic feed;
    logic offset;
    logic [7:0] chan_byte;
  } crp_core_s;
  crp_link_s lk_r, lk_nxt;
  crp_core_s st_r, st_nxt;
  function automatic logic [7:0] card_to_char(input logic [11:0] c);
    logic [3:0] digit;
    logic [3:0] zone;
    digit = 4'h0;
    zone = {1'b1, c[11], c[10], c[9]};
    for (int i = 1; i <= 7; i++) begin
      if (c[i]) begin
        digit = 4'(i);
      end
    end
    if (c[8]) begin
      digit = digit | 4'h8;
    end
    if (c[0]) begin
      digit = 4'h9;
    end
    return {zone, digit};
  endfunction : card_to_char
  function automatic logic [2:0] ones_1to7(input logic [11:0] c);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      n = n + 3'(c[i]);
    end
    return n;
  endfunction : ones_1to7
  // link domain
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.s1 = {rp_data_i, rp_feed_fault, rp_error, rp_ready,
                 rp_card_at_read_station, rp_strobe};
    lk_nxt.s2 = lk_r.s1;
    lk_nxt.s3 = lk_r.s2;
    for (int i = 0; i < 6; i++) begin
      if (lk_r.s2[i] == lk_r.s3[i]) begin
        lk_nxt.filt[i] = lk_r.s3[i];
      end
    end
  end
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end
  // core domain
  logic strobe_s, pres_s, strobe_rise, strobe_fall, pres_rise, pres_fall;
  logic sclk_fall, shift_ev, cd_ev, preset_go;
  logic [11:0] buf_in;

  always_comb begin
    st_nxt = st_r;
    st_nxt.x1 = lk_r.filt;
    st_nxt.x2 = st_r.x1;
    st_nxt.lvl_d = st_r.x2;
    strobe_s = st_r.x2[IN_STROBE];
    pres_s = st_r.x2[IN_PRES];
    strobe_rise = strobe_s && !st_r.lvl_d[IN_STROBE];
    strobe_fall = !strobe_s && st_r.lvl_d[IN_STROBE];
    pres_rise = pres_s && !st_r.lvl_d[IN_PRES];
    pres_fall = !pres_s && st_r.lvl_d[IN_PRES];
    sclk_fall = 1'b0;
    shift_ev = 1'b0;
    cd_ev = 1'b0;
    // serial clock: twelve 1 us pulses while strobe stands
    if (strobe_s && st_r.bit_cnt < BITS_PER_COL) begin
      if (st_r.sclk_tmr == 10'(SCLK_HALF_CYC - 1)) begin
        st_nxt.sclk_tmr = '0;
        st_nxt.sclk = !st_r.sclk;
        if (st_r.sclk) begin
          sclk_fall = 1'b1;
          st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        end
      end else begin
        st_nxt.sclk_tmr = st_r.sclk_tmr + 10'h1;
      end
    end else begin
      st_nxt.sclk = 1'b0;
      st_nxt.sclk_tmr = '0;
      if (!strobe_s) begin
        st_nxt.bit_cnt = '0;
      end
    end
    // serial register: entry at top stage, exit from bottom flip-flop
    if (strobe_rise && op_punch) begin
      st_nxt.serial_shift_reg = st_r.bufr[BUF_RANKS-1];
    end else if (sclk_fall) begin
      st_nxt.serial_shift_reg = {st_r.x2[IN_DATA],
                                 st_r.serial_shift_reg[11:1]};
    end
    // timing chain
    if (pres_fall) begin
      st_nxt.chain_en = 1'b1;
    end
    case (st_r.chain)
      CH_IDLE: begin
        if (st_r.chain_en) begin
          st_nxt.chain = CH_PH1;
          st_nxt.chain_tmr = '0;
          shift_ev = 1'b1;
        end
      end
      CH_PH1: begin
        st_nxt.chain_tmr = st_r.chain_tmr + 10'h1;
        if (st_r.chain_tmr == 10'(PHASE1_CYC - 1)) begin
          st_nxt.chain = CH_PH2;
          st_nxt.chain_tmr = '0;
        end
      end
      CH_PH2: begin
        st_nxt.chain_tmr = st_r.chain_tmr + 10'h1;
        if (st_r.chain_tmr == 10'(PHASE2_CYC - 1)) begin
          cd_ev = 1'b1;
          st_nxt.chain = CH_IDLE;
          st_nxt.chain_tmr = '0;
        end
      end
      default: begin
        st_nxt.chain = CH_IDLE;
      end
    endcase
    if (strobe_fall && op_read) begin
      shift_ev = 1'b1;
      cd_ev = 1'b1;
    end
    if (chan_shift) begin
      shift_ev = 1'b1;
      cd_ev = 1'b1;
    end
    // buffer: no recirculation of the last rank
    buf_in = op_read ? st_r.serial_shift_reg : punch_col;
    if (shift_ev) begin
      st_nxt.bufr = {st_r.bufr[BUF_RANKS-2:0], buf_in};
    end
    // column counter; counts are ignored while the preset pulse stands
    st_nxt.underflow = 1'b0;
    preset_go = pres_rise || st_r.underflow;
    if (preset_go) begin
      st_nxt.preset_tmr = 10'(PRESET_CYC);
      st_nxt.cnt = pres_s ? PRESET_READ : PRESET_XFER;
    end else if (st_r.preset_tmr != '0) begin
      st_nxt.preset_tmr = st_r.preset_tmr - 10'h1;
    end else if (cd_ev) begin
      if (st_r.cnt == '0) begin
        st_nxt.underflow = 1'b1;
        st_nxt.load_complete = !st_r.load_complete;
        st_nxt.chain_en = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt - 7'h1;
      end
    end
    // sense flags: set wins over clear
    if (sense_clear) begin
      st_nxt.cmd_rej = 1'b0;
      st_nxt.dchk = 1'b0;
      st_nxt.echk = 1'b0;
      st_nxt.ireq = 1'b0;
    end
    if (cond_cmd_reject) begin
      st_nxt.cmd_rej = 1'b1;
    end
    if (cond_data_check || (bad_punch_combo && op_read && op_translate &&
        chan_shift)) begin
      st_nxt.dchk = 1'b1;
    end
    if (st_r.x2[IN_ERR]) begin
      st_nxt.echk = 1'b1;
    end
    if (cond_intervention || st_r.x2[IN_FFAULT]) begin
      st_nxt.ireq = 1'b1;
    end
    if (status_clear) begin
      st_nxt.unit_check = 1'b0;
    end
    if (!op_sense && ((st_nxt.cmd_rej && !st_r.cmd_rej) ||
        (st_nxt.dchk && !st_r.dchk) || (st_nxt.echk && !st_r.echk) ||
        (st_nxt.ireq && !st_r.ireq))) begin
      st_nxt.unit_check = 1'b1;
    end
    // line direction follows card_at_read_station
    st_nxt.data_oe = !pres_s;
    st_nxt.data_o = st_r.serial_shift_reg[0];
    st_nxt.feed = feed_req;
    st_nxt.offset = feed_req && offset_req;
    case (chan_sel)
      SEL_XLATE: st_nxt.chan_byte = card_to_char(st_r.bufr[BUF_RANKS-1]);
      SEL_IMG_HI: st_nxt.chan_byte = {2'h0, st_r.bufr[BUF_RANKS-1][11:6]};
      SEL_IMG_LO: st_nxt.chan_byte = {2'h0, st_r.bufr[BUF_RANKS-1][5:0]};
      default: st_nxt.chan_byte = 8'h00;
    endcase
  end

  // bits 1..7 only; 12/11/0 zones are legal in combination
  assign bad_punch_combo = ones_1to7(st_r.bufr[BUF_RANKS-1]) > 3'h1;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rp_data_o = st_r.data_o;
  assign rp_data_oe = st_r.data_oe;
  assign rp_sclk = st_r.sclk;
  assign rp_feed = st_r.feed;
  assign rp_offset = st_r.offset;
  assign chan_byte = st_r.chan_byte;
  assign buf_out = st_r.bufr[BUF_RANKS-1];
  assign sense_cmd_reject = st_r.cmd_rej;
  assign sense_data_check = st_r.dchk;
  assign sense_equip_check = st_r.echk;
  assign sense_interv_req = st_r.ireq;
  assign unit_check = st_r.unit_check;
  assign load_complete = st_r.load_complete;
  assign counter_underflow = st_r.underflow;
  assign rdr_ready = st_r.x2[IN_READY];
  assign rdr_feed_fault = st_r.x2[IN_FFAULT];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_sclk_high;
    $rose(st_r.sclk) ##HALF_A $fell(st_r.sclk);
  endsequence

  a_sclk_half_period: assert property ($rose(st_r.sclk) |-> s_sclk_high)
    else $error("serial clock high phase wrong length");
  a_twelve_pulses: assert property (
    (st_r.bit_cnt == BITS_PER_COL) |-> !st_r.sclk)
    else $error("serial clock pulse beyond twelve");
  a_read_load: assert property (
    (strobe_fall && op_read) |=> st_r.bufr[0] == $past(st_r.serial_shift_reg))
    else $error("strobe drop did not load buffer");
  a_buf_advance: assert property (
    shift_ev |=> st_r.bufr[BUF_RANKS-1] == $past(st_r.bufr[BUF_RANKS-2]))
    else $error("buffer rank did not advance");
  a_dchk_cause: assert property (
    $rose(st_r.dchk) |-> $past(cond_data_check) ||
      $past(op_read && op_translate && bad_punch_combo))
    else $error("data check set outside translated read");
  a_unit_follow: assert property (
    ($rose(st_r.echk) && !$past(op_sense)) |-> st_r.unit_check)
    else $error("unit check missed on sense flag");
  a_line_float: assert property (pres_s |=> !st_r.data_oe)
    else $error("driver on during card_at_read_station");
  a_uflow_toggle: assert property (
    st_r.underflow |-> st_r.load_complete != $past(st_r.load_complete))
    else $error("load complete did not toggle");
  a_preset_read: assert property (pres_rise |=> st_r.cnt == PRESET_READ)
    else $error("counter not preset to read value");
endmodule : crp_data_path

// ---- crp_data_path_tb.sv ----
// self-checking bench for the card reader/punch data path.
// assumes crp_pkg, the data path and crp_rdr_model are compiled first.
`timescale 1ns/1ps
module crp_data_path_tb import crp_pkg::*;;
  logic core_clk, link_clk, reset_n, link_rst_n, idle_pat, line;
  logic op_read, op_punch, op_translate, op_sense, feed_req, offset_req;
  logic chan_shift, sense_clear, status_clear, cond_cmd_reject;
  logic cond_data_check, cond_intervention, rp_strobe, rp_pres, rp_ready;
  logic rp_error, rp_ffault, drv, d, rp_data_o, rp_data_oe, rp_sclk;
  logic rp_feed, rp_offset, bad_punch_combo, sense_cmd_reject;
  logic sense_data_check, sense_equip_check, sense_interv_req, unit_check;
  logic load_complete, counter_underflow, rdr_ready, rdr_feed_fault;
  logic [1:0] chan_sel;
  logic [11:0] punch_col, buf_out, got;
  logic [7:0] chan_byte;
  int mismatches, comparisons, sclk_n, uf_n, i;
  time t_last, per;
  // released line must not look like held data
  assign line = rp_data_oe ? rp_data_o : (drv ? d : idle_pat);
  always #5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge link_clk) idle_pat <= ~idle_pat;
  always @(posedge rp_sclk) begin
    per = $time - t_last;
    t_last = $time;
    sclk_n++;
  end
  always @(posedge core_clk) if (counter_underflow === 1'b1) uf_n++;
  crp_data_path dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .link_clk(link_clk), .link_rst_n(link_rst_n), .rp_strobe(rp_strobe),
    .rp_card_at_read_station(rp_pres), .rp_ready(rp_ready),
    .rp_error(rp_error), .rp_feed_fault(rp_ffault), .rp_data_i(line),
    .rp_data_o(rp_data_o), .rp_data_oe(rp_data_oe), .rp_sclk(rp_sclk),
    .rp_feed(rp_feed), .rp_offset(rp_offset), .op_read(op_read),
    .op_punch(op_punch), .op_translate(op_translate), .op_sense(op_sense),
    .feed_req(feed_req), .offset_req(offset_req), .chan_shift(chan_shift),
    .chan_sel(chan_sel), .punch_col(punch_col),
    .cond_cmd_reject(cond_cmd_reject), .cond_data_check(cond_data_check),
    .cond_intervention(cond_intervention), .sense_clear(sense_clear),
    .status_clear(status_clear), .chan_byte(chan_byte), .buf_out(buf_out),
    .bad_punch_combo(bad_punch_combo), .sense_cmd_reject(sense_cmd_reject),
    .sense_data_check(sense_data_check),
    .sense_equip_check(sense_equip_check),
    .sense_interv_req(sense_interv_req), .unit_check(unit_check),
    .load_complete(load_complete), .counter_underflow(counter_underflow),
    .rdr_ready(rdr_ready), .rdr_feed_fault(rdr_feed_fault));
  crp_rdr_model rdr_u (.link_clk(link_clk), .rp_sclk(rp_sclk), .line(line),
    .strobe(rp_strobe), .pres(rp_pres), .ready(rp_ready), .err(rp_error),
    .ffault(rp_ffault), .drv(drv), .d(d));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic chk1(input logic e, input logic g);
    chk({11'h000, e}, {11'h000, g});
  endtask : chk1
  task automatic shift1();
    chan_shift = 1'b1;
    tick(1);
    chan_shift = 1'b0;
    tick(1);
  endtask : shift1
  task automatic clr();
    {sense_clear, status_clear} = 2'h3;
    tick(1);
    {sense_clear, status_clear} = 2'h0;
    tick(2);
  endtask : clr
  task automatic t_feed();
    {feed_req, offset_req} = 2'h3;
    tick(2);
    chk1(1'b1, rp_feed);
    chk1(1'b1, rp_offset);
    offset_req = 1'b0;
    tick(2);
    chk1(1'b0, rp_offset);
    feed_req = 1'b0;
    tick(2);
    chk1(1'b0, rp_feed);
  endtask : t_feed
  task automatic t_sense();
    {op_sense, cond_cmd_reject} = 2'h3;
    tick(1);
    cond_cmd_reject = 1'b0;
    tick(2);
    chk1(1'b1, sense_cmd_reject);
    chk1(1'b0, unit_check); // held off while sensing
    op_sense = 1'b0;
    rdr_u.status(1'b0, 1'b1, 1'b0);
    tick(30);
    chk1(1'b1, sense_equip_check);
    chk1(1'b1, unit_check);
    cond_data_check = 1'b1;
    tick(1);
    cond_data_check = 1'b0;
    rdr_u.status(1'b1, 1'b0, 1'b1);
    tick(30);
    chk1(1'b1, sense_data_check);
    chk1(1'b1, rdr_ready);
    chk1(1'b1, rdr_feed_fault);
    chk1(1'b1, sense_interv_req);
    rdr_u.status(1'b0, 1'b0, 1'b0);
    tick(30);
    chk1(1'b0, rdr_feed_fault);
    clr();
    chk1(1'b0, sense_cmd_reject);
    chk1(1'b0, unit_check);
    cond_intervention = 1'b1;
    tick(1);
    cond_intervention = 1'b0;
    tick(1);
    chk1(1'b1, sense_interv_req);
    clr();
  endtask : t_sense
  task automatic t_read();
    {op_read, op_translate} = 2'h3;
    rdr_u.card(1'b1);
    tick(700);
    chk1(1'b0, rp_data_oe);
    sclk_n = 0;
    rdr_u.xfer(12'h803, got);
    chk(12'h00c, sclk_n[11:0]);
    chk(12'h3e8, per[11:0]);
    rdr_u.xfer(12'h0c1, got);
    rdr_u.card(1'b0);
    for (i = 0; i < 30000 && load_complete !== 1'b1; i++) tick(1);
    chk1(1'b1, load_complete);
    chk(12'h803, buf_out); // 100 shifts in all
    chk1(1'b0, bad_punch_combo);
    chk1(1'b1, rp_data_oe);
  endtask : t_read
  task automatic t_chan();
    tick(600);
    chan_sel = SEL_IMG_HI;
    tick(2);
    chk(12'h020, {4'h0, chan_byte});
    chan_sel = SEL_IMG_LO;
    tick(2);
    chk(12'h003, {4'h0, chan_byte});
    chan_sel = 2'h3;
    tick(2);
    chk(12'h000, {4'h0, chan_byte});
    chan_sel = SEL_XLATE;
    uf_n = 0;
    shift1();
    chk(12'h0c1, buf_out);
    chk(12'h089, {4'h0, chan_byte}); // zone 8, digit 9
    chk1(1'b1, bad_punch_combo);
    repeat (77) shift1();
    chk1(1'b1, load_complete);
    shift1();
    tick(3);
    chk1(1'b0, load_complete);
    chk(12'h001, uf_n[11:0]); // preset 78, 79th pulse
    chk1(1'b1, sense_data_check);
    chk1(1'b1, unit_check);
  endtask : t_chan
  // mid-run clear: flags set by t_chan must drop while reset stands
  task automatic t_reset();
    reset_n = 1'b0;
    tick(2);
    chk1(1'b0, unit_check);
    chk1(1'b0, sense_data_check);
    chk(12'h000, buf_out);
    reset_n = 1'b1;
    tick(2);
  endtask : t_reset
  task automatic t_punch();
    {op_read, op_translate, op_punch} = 3'h1;
    clr();
    for (i = 0; i < BUF_RANKS; i++) begin
      punch_col = 12'h0c1 ^ 12'(i);
      shift1();
    end
    chk(12'h0c1, buf_out);
    chk1(1'b0, sense_data_check);
    rdr_u.xfer(12'hfff, got);
    chk(12'h0c1, got); // lsb leaves first
    chk1(1'b1, rp_data_oe);
  endtask : t_punch
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    {core_clk, link_clk, reset_n, link_rst_n, idle_pat} = 5'h00;
    {op_read, op_punch, op_translate, op_sense, feed_req} = 5'h00;
    {offset_req, chan_shift, sense_clear, status_clear} = 4'h0;
    {cond_cmd_reject, cond_data_check, cond_intervention} = 3'h0;
    {chan_sel, punch_col} = 14'h0000;
    {mismatches, comparisons, sclk_n, uf_n} = {4{32'h0000_0000}};
    {t_last, per} = {2{64'h0000_0000_0000_0000}};
    repeat (4) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge link_clk);
    #1;
    link_rst_n = 1'b1;
    tick(4);
    t_feed();
    t_sense();
    t_read();
    t_chan();
    t_reset();
    t_punch();
    tally_and_finish();
  end
  // whole run is near 21k cycles; some five times that means a hang
  initial begin
    #1_000_000;
    mismatches++;
    tally_and_finish();
  end
endmodule : crp_data_path_tb

// ---- crp_pkg.sv ----
// constants for the card reader/punch data path.
// assumes a 100 MHz core clock; the link side runs on its own clock.
package crp_pkg;
  localparam int SER_BITS = 12;
  localparam int BUF_RANKS = 100;
  localparam int CORE_NS = 10;
  localparam int SCLK_NS = 1000;
  localparam int PHASE1_NS = 500;
  localparam int PHASE2_NS = 1000;
  localparam int PRESET_NS = 5000;
  localparam int SCLK_HALF_CYC = SCLK_NS / (2 * CORE_NS);
  localparam int PHASE1_CYC = (PHASE1_NS + CORE_NS - 1) / CORE_NS;
  localparam int PHASE2_CYC = (PHASE2_NS + CORE_NS - 1) / CORE_NS;
  localparam int PRESET_CYC = (PRESET_NS + CORE_NS - 1) / CORE_NS;
  localparam logic [6:0] PRESET_READ = 7'h63;
  localparam logic [6:0] PRESET_XFER = 7'h4e;
  localparam logic [3:0] BITS_PER_COL = 4'hc;
  localparam int IN_STROBE = 0;
  localparam int IN_PRES = 1;
  localparam int IN_READY = 2;
  localparam int IN_ERR = 3;
  localparam int IN_FFAULT = 4;
  localparam int IN_DATA = 5;
  localparam logic [1:0] SEL_XLATE = 2'h0;
  localparam logic [1:0] SEL_IMG_HI = 2'h1;
  localparam logic [1:0] SEL_IMG_LO = 2'h2;
  typedef enum logic [1:0] {CH_IDLE, CH_PH1, CH_PH2} crp_chain_e;
endpackage : crp_pkg

// ---- crp_rdr_model.sv ----
// reader/punch mechanism model on the link clock.
// assumes the bench resolves the shared data line and calls its tasks.
`timescale 1ns/1ps
module crp_rdr_model (
  input wire logic link_clk,
  input wire logic rp_sclk,
  input wire logic line,
  output logic strobe,
  output logic pres,
  output logic ready,
  output logic err,
  output logic ffault,
  output logic drv,
  output logic d
);
  logic s_q;
  initial begin
    {strobe, pres, ready, err, ffault, drv, d, s_q} = 8'h00;
  end
  task automatic card(input logic on);
    @(posedge link_clk);
    pres <= on;
  endtask : card
  task automatic status(input logic r, input logic e, input logic f);
    @(posedge link_clk);
    ready <= r;
    err <= e;
    ffault <= f;
  endtask : status
  // bits go lsb first; new bit set on each clock rise, far from the fall
  task automatic xfer(input logic [11:0] col, output logic [11:0] got);
    int n;
    n = 0;
    got = 12'h000;
    @(posedge link_clk);
    strobe <= 1'b1;
    drv <= pres; // drive only while a card is read
    while (n < 12) begin
      @(posedge link_clk);
      if (rp_sclk && !s_q) begin
        d <= col[n];
        got[n] = line;
      end
      if (!rp_sclk && s_q) n++;
      s_q = rp_sclk;
    end
    strobe <= 1'b0; // drop after the twelfth bit
    drv <= 1'b0;
    repeat (40) @(posedge link_clk);
  endtask : xfer
endmodule : crp_rdr_model
